// ===== design/aws_consts.svh
// Constants for the automatic wake/sleep timing block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 250 MHz core clock and register accesses from the serial slave.
//
// Summary of operation
// - Wake idle high nibble, bits 7:4 read zero
// - Wake idle applies only in flexible wake mode
// - Sleep idle applies only in flexible sleep mode
// - Sleep idle: 12-bit count of 312.5 us steps
// - Flexible period equals idle plus measurement time
// - Sleep only after counter reaches programmed limit
// - Inactivity limit is 12 bits over two registers
// - Counter ticks once per wake sample period
// - Zero inactivity limit disables automatic switching
// - Wake uses wake power, rate, decimation, idle
// - Sleep uses sleep power, rate, decimation, idle
// - Monitored activity functions chosen by enable settings
// - Same events wake; buffer flag only delays sleep
// - Enabled activity event wakes sleeping device at once
// - Motion flags clear and wake; buffer only clears
// - Buffer flag clear resets counter when enabled
// - Buffer flags ignored when keep-awake setting is 0
// - Gate buffer after transition until host empties it
// - Wake idle: 12-bit count, low byte separate
`ifndef AWS_CONSTS_SVH
`define AWS_CONSTS_SVH

`define AWS_OFS_WAKE_IDLE_LOW   8'h1a
`define AWS_OFS_WAKE_IDLE_HIGH  8'h1b
`define AWS_OFS_SLEEP_IDLE_LOW  8'h1c
`define AWS_OFS_SLEEP_IDLE_HIGH 8'h1d
`define AWS_OFS_INACT_LOW       8'h1e
`define AWS_OFS_INACT_HIGH      8'h1f

`define AWS_RESET_BYTE          8'h00
`define AWS_RESET_NIBBLE        4'h0
`define AWS_FLEX_BIT            1

`define AWS_CLK_PERIOD_PS       4000
`define AWS_IDLE_STEP_PS        312500000
`define AWS_IDLE_STEP_CYC       ((`AWS_IDLE_STEP_PS + `AWS_CLK_PERIOD_PS - 1) / `AWS_CLK_PERIOD_PS)
`define AWS_MEAS_UNIT_PS        312500000
`define AWS_MEAS_UNIT_CYC       ((`AWS_MEAS_UNIT_PS + `AWS_CLK_PERIOD_PS - 1) / `AWS_CLK_PERIOD_PS)

`endif

// ===== design/aws_pkg.sv
// Types shared by the automatic wake/sleep timing block.
// Assumes the constants header is included where offsets are needed.
package aws_pkg;

	// Event source flags as presented by the interrupt source logic
	typedef struct packed {
		logic new_sample;
		logic overrun;
		logic buffer_event;
		logic outside_threshold;
		logic within_threshold;
		logic orientation_change;
		logic autosleep_change;
		logic boot_done;
	} aws_flags_t;

	// Per-mode operating settings
	typedef struct packed {
		logic [1:0] power_select;
		logic [3:0] rate_select;
		logic [3:0] decimation;
	} aws_mode_cfg_t;

	typedef enum logic [1:0] {
		AWS_WAKE  = 2'b01,
		AWS_SLEEP = 2'b10
	} aws_state_t;

endpackage

// ===== design/aws_timer.sv
// Automatic wake/sleep timing: idle-time and inactivity-limit registers,
// flexible-mode period generator, inactivity counter and mode state.
// Assumes register accesses and event flags are synchronous to core_clk_i.
`timescale 1ns/100ps
`include "aws_consts.svh"

module aws_timer #(
	parameter int unsigned IDLE_STEP_CYC = `AWS_IDLE_STEP_CYC,
	parameter int unsigned MEAS_UNIT_CYC = `AWS_MEAS_UNIT_CYC
) (
	input  wire logic                   core_clk_i,            // Core clock, 250 MHz
	input  wire logic                   rst_n_i,               // Async reset, active low
	input  wire logic                   reg_wr_i,              // Register write strobe
	input  wire logic                   reg_rd_i,              // Register read strobe
	input  wire logic [7:0]             reg_addr_i,            // Register address
	input  wire logic [7:0]             reg_wdata_i,           // Register write data
	output logic      [7:0]             reg_rdata_o,           // Register read data
	output logic                        reg_hit_o,             // Address is one of ours
	input  wire aws_pkg::aws_mode_cfg_t active_cfg_i,          // Wake power/rate/decimation
	input  wire aws_pkg::aws_mode_cfg_t dormant_cfg_i,         // Sleep power/rate/decimation
	input  wire logic [2:0]             activity_enable_i,     // Outside, within, orientation
	input  wire logic                   buffer_keeps_awake_i,  // Buffer clear holds off sleep
	input  wire logic                   buffer_gate_i,         // Gate buffer at transitions
	input  wire aws_pkg::aws_flags_t    flags_i,               // Event source flags
	input  wire logic                   buffer_flag_clear_i,   // Host cleared buffer flag
	input  wire logic                   buffer_empty_i,        // Output buffer is empty
	input  wire logic                   rate_tick_i,           // Fixed-rate period pulse
	output logic                        sleep_mode_o,          // Device is in sleep
	output aws_pkg::aws_mode_cfg_t      mode_cfg_o,            // Settings now in force
	output logic                        sample_tick_o,         // One pulse per sample period
	output logic                        mode_change_o,         // Pulse on each transition
	output logic                        buffer_accept_o        // Buffer may take samples
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Upper bound keeps the longest flexible period inside the 32-bit counter
	if (IDLE_STEP_CYC == 0 || MEAS_UNIT_CYC == 0 || IDLE_STEP_CYC > 32'h0008_0000 ||
		MEAS_UNIT_CYC > 32'h0008_0000) begin : g_bad_steps
		$error("aws_timer: step counts must lie in 1..524288");
	end

	// Cycles in one flexible period: idle plus decimation-set measurement time
	function automatic logic [31:0] flex_period(input logic [11:0] idle, input logic [3:0] dec);
		logic [31:0] idle_c;
		logic [31:0] meas_c;
		idle_c = 32'(idle) * 32'(IDLE_STEP_CYC);
		meas_c = (32'(dec) + 32'h1) * 32'(MEAS_UNIT_CYC);
		flex_period = idle_c + meas_c;
	endfunction

	// ************************************************************
	// Register file
	// ************************************************************
	logic [7:0]  wake_idle_low_reg,   wake_idle_low_next;
	logic [3:0]  wake_idle_high_reg,  wake_idle_high_next;
	logic [7:0]  sleep_idle_low_reg,  sleep_idle_low_next;
	logic [3:0]  sleep_idle_high_reg, sleep_idle_high_next;
	logic [7:0]  inact_low_reg,       inact_low_next;
	logic [3:0]  inact_high_reg,      inact_high_next;
	logic [7:0]  rdata_reg,           rdata_next;
	logic [11:0] wake_idle;
	logic [11:0] sleep_idle;
	logic [11:0] inactivity_limit;

	assign wake_idle        = {wake_idle_high_reg, wake_idle_low_reg};
	assign sleep_idle       = {sleep_idle_high_reg, sleep_idle_low_reg};
	assign inactivity_limit = {inact_high_reg, inact_low_reg};

	always_comb begin
		wake_idle_low_next   = wake_idle_low_reg;
		wake_idle_high_next  = wake_idle_high_reg;
		sleep_idle_low_next  = sleep_idle_low_reg;
		sleep_idle_high_next = sleep_idle_high_reg;
		inact_low_next       = inact_low_reg;
		inact_high_next      = inact_high_reg;
		rdata_next           = rdata_reg;
		reg_hit_o            = 1'b1;
		// Upper nibbles are not stored, so they always read back as zero
		case (reg_addr_i)
			`AWS_OFS_WAKE_IDLE_LOW: begin
				if (reg_wr_i) wake_idle_low_next = reg_wdata_i;
				if (reg_rd_i) rdata_next = wake_idle_low_reg;
			end
			`AWS_OFS_WAKE_IDLE_HIGH: begin
				if (reg_wr_i) wake_idle_high_next = reg_wdata_i[3:0];
				if (reg_rd_i) rdata_next = {4'h0, wake_idle_high_reg};
			end
			`AWS_OFS_SLEEP_IDLE_LOW: begin
				if (reg_wr_i) sleep_idle_low_next = reg_wdata_i;
				if (reg_rd_i) rdata_next = sleep_idle_low_reg;
			end
			`AWS_OFS_SLEEP_IDLE_HIGH: begin
				if (reg_wr_i) sleep_idle_high_next = reg_wdata_i[3:0];
				if (reg_rd_i) rdata_next = {4'h0, sleep_idle_high_reg};
			end
			`AWS_OFS_INACT_LOW: begin
				if (reg_wr_i) inact_low_next = reg_wdata_i;
				if (reg_rd_i) rdata_next = inact_low_reg;
			end
			`AWS_OFS_INACT_HIGH: begin
				if (reg_wr_i) inact_high_next = reg_wdata_i[3:0];
				if (reg_rd_i) rdata_next = {4'h0, inact_high_reg};
			end
			default: begin
				reg_hit_o = 1'b0;
				if (reg_rd_i) rdata_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_idle_low_reg   <= `AWS_RESET_BYTE;
			wake_idle_high_reg  <= `AWS_RESET_NIBBLE;
			sleep_idle_low_reg  <= `AWS_RESET_BYTE;
			sleep_idle_high_reg <= `AWS_RESET_NIBBLE;
			inact_low_reg       <= `AWS_RESET_BYTE;
			inact_high_reg      <= `AWS_RESET_NIBBLE;
			rdata_reg           <= 8'h00;
		end else begin
			wake_idle_low_reg   <= wake_idle_low_next;
			wake_idle_high_reg  <= wake_idle_high_next;
			sleep_idle_low_reg  <= sleep_idle_low_next;
			sleep_idle_high_reg <= sleep_idle_high_next;
			inact_low_reg       <= inact_low_next;
			inact_high_reg      <= inact_high_next;
			rdata_reg           <= rdata_next;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ************************************************************
	// Sample period generator
	// ************************************************************
	aws_pkg::aws_state_t    state_reg, state_next;
	aws_pkg::aws_mode_cfg_t cur_cfg;
	logic [11:0]            cur_idle;
	logic                   flex_mode;
	logic [31:0]            period_cyc;
	logic [31:0]            per_cnt_reg, per_cnt_next;
	logic [31:0]            per_cnt_run;
	logic                   tick_now;
	logic                   tick_reg;

	// Settings follow the current mode; idle time only counts in flexible mode
	assign cur_cfg    = (state_reg == aws_pkg::AWS_SLEEP) ? dormant_cfg_i : active_cfg_i;
	assign cur_idle   = (state_reg == aws_pkg::AWS_SLEEP) ? sleep_idle : wake_idle;
	assign flex_mode  = cur_cfg.power_select[`AWS_FLEX_BIT];
	assign period_cyc = flex_period(cur_idle, cur_cfg.decimation);

	always_comb begin
		per_cnt_run = per_cnt_reg + 32'h1;
		tick_now    = 1'b0;
		if (!flex_mode) begin
			per_cnt_run = 32'h0;
			tick_now    = rate_tick_i;
		end else if (per_cnt_reg + 32'h1 >= period_cyc) begin
			per_cnt_run = 32'h0;
			tick_now    = 1'b1;
		end
	end

	// Restart kept apart from the tick so the tick never depends on the next state
	assign per_cnt_next = (state_next != state_reg) ? 32'h0 : per_cnt_run;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_cnt_reg <= 32'h0;
			tick_reg    <= 1'b0;
		end else begin
			per_cnt_reg <= per_cnt_next;
			tick_reg    <= tick_now;
		end
	end

	assign sample_tick_o = tick_reg;

	// ************************************************************
	// Inactivity counter and mode state
	// ************************************************************
	logic [11:0] inact_cnt_reg, inact_cnt_next;
	logic        motion_hit;
	logic        buffer_hit;
	logic        auto_enabled;
	logic        gate_reg, gate_next;
	logic        change_reg, change_next;
	aws_pkg::aws_mode_cfg_t cfg_reg, cfg_next;

	// Buffer activity may hold off sleep but never ends it
	assign motion_hit   = |(activity_enable_i & {flags_i.outside_threshold, flags_i.within_threshold,
		flags_i.orientation_change});
	assign buffer_hit   = buffer_keeps_awake_i & buffer_flag_clear_i;
	assign auto_enabled = (inactivity_limit != 12'h000);

	always_comb begin
		state_next     = state_reg;
		inact_cnt_next = inact_cnt_reg;
		case (state_reg)
			aws_pkg::AWS_WAKE: begin
				if (!auto_enabled || motion_hit || buffer_hit) begin
					inact_cnt_next = 12'h000;
				end else if (tick_now) begin
					// Compare one ahead so the limit-th period ends the wait
					if (inact_cnt_reg + 12'h001 >= inactivity_limit) begin
						state_next     = aws_pkg::AWS_SLEEP;
						inact_cnt_next = 12'h000;
					end else begin
						inact_cnt_next = inact_cnt_reg + 12'h001;
					end
				end
			end
			aws_pkg::AWS_SLEEP: begin
				inact_cnt_next = 12'h000;
				if (motion_hit || !auto_enabled) begin
					state_next = aws_pkg::AWS_WAKE;
				end
			end
			default: begin
				state_next     = aws_pkg::AWS_WAKE;
				inact_cnt_next = 12'h000;
			end
		endcase
		gate_next = gate_reg;
		if (buffer_gate_i && state_next != state_reg) begin
			gate_next = 1'b1;
		end else if (buffer_empty_i) begin
			gate_next = 1'b0;
		end
		change_next = (state_next != state_reg);
		cfg_next    = (state_next == aws_pkg::AWS_SLEEP) ? dormant_cfg_i : active_cfg_i;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= aws_pkg::AWS_WAKE;
			inact_cnt_reg <= 12'h000;
			gate_reg      <= 1'b0;
			change_reg    <= 1'b0;
			cfg_reg       <= '0;
		end else begin
			state_reg     <= state_next;
			inact_cnt_reg <= inact_cnt_next;
			gate_reg      <= gate_next;
			change_reg    <= change_next;
			cfg_reg       <= cfg_next;
		end
	end

	assign sleep_mode_o    = (state_reg == aws_pkg::AWS_SLEEP);
	assign mode_change_o   = change_reg;
	assign buffer_accept_o = ~gate_reg;
	assign mode_cfg_o      = cfg_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_high_nibble_zero;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == `AWS_OFS_WAKE_IDLE_HIGH) |=> (reg_rdata_o[7:4] == 4'h0);
	endproperty
	a_high_nibble_zero: assert property (p_high_nibble_zero)
		else $error("wake idle high read shows upper bits");

	property p_zero_limit_no_sleep;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!sleep_mode_o && inactivity_limit == 12'h000) |=> !sleep_mode_o;
	endproperty
	a_zero_limit_no_sleep: assert property (p_zero_limit_no_sleep)
		else $error("sleep entered with zero limit");

	property p_motion_wakes;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(sleep_mode_o && motion_hit) |=> (!sleep_mode_o && mode_change_o);
	endproperty
	a_motion_wakes: assert property (p_motion_wakes)
		else $error("enabled event did not wake device");

	property p_motion_clears;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!sleep_mode_o && motion_hit) |=> (inact_cnt_reg == 12'h000 && !sleep_mode_o);
	endproperty
	a_motion_clears: assert property (p_motion_clears)
		else $error("motion event did not clear counter");

	property p_buffer_clear_holds;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!sleep_mode_o && buffer_keeps_awake_i && buffer_flag_clear_i) |=>
			(inact_cnt_reg == 12'h000 && !sleep_mode_o);
	endproperty
	a_buffer_clear_holds: assert property (p_buffer_clear_holds)
		else $error("buffer flag clear did not hold off sleep");

	property p_sleep_after_limit;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(sleep_mode_o) |-> ($past(inact_cnt_reg) + 12'h001 >= $past(inactivity_limit) && sample_tick_o);
	endproperty
	a_sleep_after_limit: assert property (p_sleep_after_limit)
		else $error("sleep entered before limit reached");

	property p_wake_restarts;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(sleep_mode_o) |-> (inact_cnt_reg == 12'h000);
	endproperty
	a_wake_restarts: assert property (p_wake_restarts)
		else $error("counter not zero on wake entry");

	property p_gate_on_change;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(buffer_gate_i && state_next != state_reg) |=> !buffer_accept_o;
	endproperty
	a_gate_on_change: assert property (p_gate_on_change)
		else $error("buffer not gated after transition");

	property p_fixed_rate_tick;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!flex_mode && rate_tick_i && state_next == state_reg) |=> sample_tick_o;
	endproperty
	a_fixed_rate_tick: assert property (p_fixed_rate_tick)
		else $error("fixed-rate period not passed through");

	property p_sleep_cfg;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(sleep_mode_o && $stable(dormant_cfg_i)) |-> ##1 (mode_cfg_o == $past(dormant_cfg_i) || !sleep_mode_o);
	endproperty
	a_sleep_cfg: assert property (p_sleep_cfg)
		else $error("sleep settings not in force");

endmodule // aws_timer

// ===== bench/aws_host_model.sv
// Host-side partner: clears the buffer event flag and empties the output buffer.
// Assumes requests come as one-cycle pulses synchronous to core_clk_i.
`timescale 1ns/100ps

module aws_host_model #(
	parameter int unsigned DRAIN_CYC = 6
) (
	input  wire logic core_clk_i,          // Core clock
	input  wire logic rst_n_i,             // Async reset, active low
	input  wire logic clear_req_i,         // Bench asks for a flag clear
	input  wire logic drain_req_i,         // Bench asks for a buffer drain
	input  wire logic sample_tick_i,       // Device sample period pulse
	input  wire logic accept_i,            // Buffer may take samples
	output logic      buffer_flag_clear_o, // Flag clear pulse
	output logic      buffer_empty_o       // Buffer holds nothing
);
	int unsigned drain_cnt;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buffer_flag_clear_o <= 1'h0;
			buffer_empty_o      <= 1'h1;
			drain_cnt           <= 0;
		end else begin
			buffer_flag_clear_o <= clear_req_i;
			if (drain_req_i)
				drain_cnt <= DRAIN_CYC;
			else if (drain_cnt != 0)
				drain_cnt <= drain_cnt - 1;
			// Reading out takes time, so empty shows only at the end of a drain
			if (drain_cnt == 1)
				buffer_empty_o <= 1'h1;
			else if (sample_tick_i && accept_i)
				buffer_empty_o <= 1'h0;
		end
	end
endmodule // aws_host_model

// ===== bench/tb_top.sv
// Self-checking testbench for the automatic wake/sleep timing block.
// Assumes the design package and constants header are on the compile path.
`timescale 1ns/100ps

module tb_top;
	localparam int unsigned IDLE_CYC = 4;
	localparam int unsigned MEAS_CYC = 2;
	localparam int unsigned DRAIN    = 6;

	logic                   core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, rate_tick_i;
	logic                   keep_i, gate_i, clear_req, drain_req, flag_clear, empty;
	logic                   hit, sleep, stick, mchg, accept;
	logic [7:0]             reg_addr_i, reg_wdata_i, rdata;
	logic [2:0]             act_en;
	aws_pkg::aws_mode_cfg_t act_cfg, dor_cfg, mode_cfg;
	aws_pkg::aws_flags_t    flags;
	int                     failures, tests_run, changes, d;

	aws_timer #(.IDLE_STEP_CYC(IDLE_CYC), .MEAS_UNIT_CYC(MEAS_CYC)) dut_u (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .reg_hit_o(hit),
		.active_cfg_i(act_cfg), .dormant_cfg_i(dor_cfg), .activity_enable_i(act_en),
		.buffer_keeps_awake_i(keep_i), .buffer_gate_i(gate_i), .flags_i(flags),
		.buffer_flag_clear_i(flag_clear), .buffer_empty_i(empty), .rate_tick_i(rate_tick_i),
		.sleep_mode_o(sleep), .mode_cfg_o(mode_cfg), .sample_tick_o(stick), .mode_change_o(mchg),
		.buffer_accept_o(accept));

	aws_host_model #(.DRAIN_CYC(DRAIN)) host_u (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clear_req_i(clear_req), .drain_req_i(drain_req),
		.sample_tick_i(stick), .accept_i(accept), .buffer_flag_clear_o(flag_clear),
		.buffer_empty_o(empty));

	initial begin
		core_clk_i = 1'h0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		if (mchg === 1'h1)
			changes++;
	end

	// ****************************************
	// Compare and access tasks
	// ****************************************
	task automatic chk1(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chkv(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'h1;
		step(1);
		reg_wr_i <= 1'h0;
		step(1);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_i <= a;
		reg_rd_i   <= 1'h1;
		#1 chk1("reg_hit", a >= 8'h1a && a <= 8'h1f, hit);
		step(1);
		reg_rd_i <= 1'h0;
		#1 chkv("reg_rdata", {24'h0, exp}, {24'h0, rdata});
		step(1);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			rate_tick_i <= 1'h1;
			step(1);
			rate_tick_i <= 1'h0;
			step(3);
		end
	endtask

	task automatic evt(input logic [7:0] f, input int n);
		flags <= aws_pkg::aws_flags_t'(f);
		step(n);
		flags <= '0;
		step(2);
	endtask

	task automatic bclr;
		clear_req <= 1'h1;
		step(1);
		clear_req <= 1'h0;
		step(3);
	endtask

	// Edges from the previous sample pulse to the next one
	task automatic wtick(output int k);
		k = 1;
		step(1);
		while (stick !== 1'h1 && k < 3000) begin
			step(1);
			k++;
		end
		if (k >= 3000)
			failures++;
	endtask

	task automatic measure(output int p);
		wtick(p);
		wtick(p);
		wtick(p);
	endtask

	task automatic print_verdict;
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		step(20000);
		failures++;
		print_verdict;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, rate_tick_i, keep_i, gate_i, clear_req, drain_req} = 8'h00;
		{reg_addr_i, reg_wdata_i, act_en, failures, tests_run, changes} = '0;
		flags   = '0;
		act_cfg = aws_pkg::aws_mode_cfg_t'(10'h134);
		dor_cfg = aws_pkg::aws_mode_cfg_t'(10'h0a1);
		step(20);
		rst_n_i <= 1'h1;
		step(1);
		for (int a = 8'h1a; a <= 8'h20; a++) rd_chk(8'(a), 8'h00);
		chk1("buffer_accept", 1'h1, accept);
		for (int a = 8'h1a; a <= 8'h20; a++) wr(8'(a), 8'hff);
		for (int a = 8'h1a; a <= 8'h20; a++) rd_chk(8'(a), a == 8'h20 ? 8'h00 : (a[0] ? 8'h0f : 8'hff));
		for (int a = 8'h1a; a <= 8'h20; a++) wr(8'(a), 8'h00);
		ticks(5);
		chk1("sleep_mode", 1'h0, sleep);
		act_en <= 3'h7;
		gate_i <= 1'h1;
		wr(8'h1e, 8'h03);
		evt(8'h10, 1);
		ticks(2);
		evt(8'h08, 1);
		ticks(2);
		chk1("sleep_mode", 1'h0, sleep);
		ticks(1);
		chk1("sleep_mode", 1'h1, sleep);
		chkv("mode_cfg", {22'h0, dor_cfg}, {22'h0, mode_cfg});
		chk1("buffer_accept", 1'h0, accept);
		evt(8'he3, 4);
		chk1("sleep_mode", 1'h1, sleep);
		drain_req <= 1'h1;
		step(1);
		drain_req <= 1'h0;
		step(DRAIN + 4);
		chk1("buffer_accept", 1'h1, accept);
		for (int i = 0; i < 3; i++) begin
			act_en <= 3'h7 & ~(3'h1 << i);
			flags  <= aws_pkg::aws_flags_t'(8'h04 << i);
			step(3);
			chk1("sleep_mode", 1'h1, sleep);
			act_en <= 3'h7;
			step(2);
			chk1("sleep_mode", 1'h0, sleep);
			chkv("mode_cfg", {22'h0, act_cfg}, {22'h0, mode_cfg});
			flags <= '0;
			ticks(2);
			chk1("sleep_mode", 1'h0, sleep);
			ticks(1);
			chk1("sleep_mode", 1'h1, sleep);
		end
		chkv("mode_changes", 32'h7, changes);
		evt(8'h10, 1);
		ticks(2);
		bclr();
		ticks(1);
		chk1("sleep_mode", 1'h1, sleep);
		evt(8'h10, 1);
		keep_i <= 1'h1;
		ticks(2);
		bclr();
		ticks(2);
		chk1("sleep_mode", 1'h0, sleep);
		ticks(1);
		bclr();
		chk1("sleep_mode", 1'h1, sleep);
		wr(8'h1e, 8'h00);
		step(2);
		chk1("sleep_mode", 1'h0, sleep);
		// Flexible wake period, then the same with the high idle nibble in use
		act_cfg <= aws_pkg::aws_mode_cfg_t'(10'h201);
		wr(8'h1a, 8'h03);
		measure(d);
		chkv("wake_period", 3 * IDLE_CYC + 2 * MEAS_CYC, d);
		wr(8'h1b, 8'h01);
		measure(d);
		chkv("wake_period", 259 * IDLE_CYC + 2 * MEAS_CYC, d);
		wr(8'h1b, 8'h00);
		dor_cfg <= aws_pkg::aws_mode_cfg_t'(10'h300);
		wr(8'h1c, 8'h05);
		wr(8'h1e, 8'h02);
		for (int k = 0; k < 200 && sleep !== 1'h1; k++) step(1);
		chk1("sleep_mode", 1'h1, sleep);
		measure(d);
		chkv("sleep_period", 5 * IDLE_CYC + 1 * MEAS_CYC, d);
		print_verdict;
	end
endmodule // tb_top
